// file: cmf_engine_model.sv
// Behavioural protocol engine model facing the CAN mailbox register block
`timescale 1ns/10ps

module cmf_engine_model
	import cmf_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Commands from the bench
	input  wire logic            try_go,
	input  wire logic            try_mb,
	input  wire cmf_result_e     try_res,
	input  wire logic [3:0]      try_len,
	input  wire logic            rx_go,
	input  wire cmf_frame_s      rx_in,
	input  wire logic [7:0]      rx_idx_in,
	// Register block side
	input  wire logic [N_TX-1:0] tx_pending,
	output logic      [N_TX-1:0] eng_busy,
	output logic      [N_TX-1:0] eng_done,
	output cmf_result_e          eng_result,
	output logic                 rx_store,
	output cmf_frame_s           rx_frame,
	output logic      [7:0]      rx_match_index,
	output logic                 idle
);
	logic        mb_reg;
	logic [3:0]  cnt_reg;
	cmf_result_e res_reg;

	assign idle = (eng_busy == '0) && (eng_done == '0);

	// ****************************************************************
	// Transmit attempts
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eng_busy   <= '0;
			eng_done   <= '0;
			eng_result <= CMF_RES_OK;
			mb_reg     <= 1'b0;
			cnt_reg    <= 4'h0;
			res_reg    <= CMF_RES_OK;
		end else begin
			eng_done <= '0;
			if (eng_busy != '0) begin
				// A frame on the bus runs to its end even when aborted
				if (cnt_reg == 4'h0) begin
					eng_busy         <= '0;
					eng_done[mb_reg] <= 1'b1;
					eng_result       <= res_reg;
				end else begin
					cnt_reg <= cnt_reg - 4'h1;
				end
			end else begin
				// Result lines mean nothing between attempts, so they keep moving
				eng_result <= cmf_result_e'(~eng_result);
				if (try_go && tx_pending[try_mb]) begin
					eng_busy[try_mb] <= 1'b1;
					mb_reg           <= try_mb;
					res_reg          <= try_res;
					cnt_reg          <= try_len;
				end
			end
		end
	end

	// ****************************************************************
	// Receive store
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_store       <= 1'b0;
			rx_frame       <= '0;
			rx_match_index <= 8'h00;
		end else begin
			rx_store <= rx_go;
			if (rx_go) begin
				rx_frame       <= rx_in;
				rx_match_index <= rx_idx_in;
			end else begin
				// Stale frame must not pass for valid outside the pulse
				rx_frame       <= ~rx_frame;
				rx_match_index <= ~rx_match_index;
			end
		end
	end

endmodule : cmf_engine_model

// file: cmf_pkg.sv
// Package for the CAN mailbox and filter register block: map, fields, types
package cmf_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int N_TX   = 2;
	localparam int N_FILT = 6;
	localparam int N_DATA = 8;

	// ****************************************************************
	// APB byte map, one 32-bit word per 8-bit register
	// ****************************************************************
	localparam logic [7:0] MB_STRIDE = 8'h40;
	localparam logic [7:0] RX_BASE   = 8'h80;
	localparam logic [7:0] FCFG_BASE = 8'hc0;
	localparam logic [7:0] TSR_ADDR  = 8'hd0;
	localparam logic [7:0] TPR_ADDR  = 8'hd4;
	localparam logic [7:0] IER_ADDR  = 8'hd8;
	// Word index within a mailbox window
	localparam logic [3:0] IDX_CTRL  = 4'h0;
	localparam logic [3:0] IDX_DLC   = 4'h1;
	localparam logic [3:0] IDX_ID0   = 4'h2;
	localparam logic [3:0] IDX_DATA0 = 4'h6;
	localparam logic [3:0] IDX_LAST  = 4'hd;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CS_TX_ERROR_FLAG = 5;
	localparam int CS_ARBITRATION_LOST_FLAG = 4;
	localparam int CS_TX_SUCCESS_FLAG = 3;
	localparam int CS_REQUEST_COMPLETED = 2;
	localparam int CS_ABORT_REQUEST = 1;
	localparam int CS_TRANSMIT_REQUEST = 0;
	localparam int ID0_RSVD = 7;
	localparam int TSR_TXOK0 = 4;
	localparam int FC_ODD_SHIFT = 4;
	localparam int FC_SCALE_LSB = 1;
	localparam logic [7:0] FCFG_MASK = 8'h77;
	localparam logic [7:0] FCFG_ACT_MASK = 8'h11;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_FMI  = 8'h00;
	localparam logic [7:0] RST_FCFG = 8'h00;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {CMF_RES_OK, CMF_RES_ARB, CMF_RES_ERR} cmf_result_e;

	typedef struct packed {
		logic [3:0][7:0]        ident;
		logic [3:0]             dlc;
		logic [N_DATA-1:0][7:0] data;
	} cmf_frame_s;

endpackage : cmf_pkg

// file: cmf_regs.sv
// CAN mailbox and acceptance filter configuration registers behind an APB slave
//
// Function
// - Error bit reflects bus error of last attempt
// - Arbitration-lost bit reflects last attempt outcome
// - Success bit per attempt, mirrored in status
// - Completed set on finish, cleared by request/write-one
// - Clearing completed clears result and mirror bits
// - Abort request only while pending, self-clears
// - Transmit request cleared when mailbox empties
// - Receive mailbox shows match index at control slot
// - Match index stored per received frame, resets zero
// - Ident byte 0: type, frame, id high
// - Ident byte 1: standard low, extended high
// - Ident bytes 2 and 3: extended bits
// - Length code bits 3:0, locked unless empty
// - Payload bytes locked unless mailbox empty
// - Active bit enables filter, locks its values
// - One config byte serves two filters
// - Transmit mailbox writable only empty; receive never
// - Interrupt on completed when enable set
`timescale 1ns/10ps

module cmf_regs
	import cmf_pkg::*;
(
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Protocol engine, transmit side
	output cmf_frame_s [N_TX-1:0]         tx_frame,
	output logic       [N_TX-1:0]         tx_pending,
	output logic       [N_TX-1:0]         tx_abort,
	input  wire logic  [N_TX-1:0]         eng_busy,
	input  wire logic  [N_TX-1:0]         eng_done,
	input  wire cmf_result_e              eng_result,
	// Protocol engine, receive side
	input  wire logic                     rx_store,
	input  wire cmf_frame_s               rx_frame,
	input  wire logic [7:0]               rx_match_index,
	// Filter configuration
	input  wire logic                     init_mode,
	output logic      [N_FILT-1:0][1:0]   filter_scale,
	output logic      [N_FILT-1:0]        filter_active,
	output logic      [N_FILT-1:0]        filter_value_lock,
	// Interrupt
	output logic                          irq_tx_empty
);

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic       setup_ph;
	logic       wr_acc;
	logic [1:0] win;
	logic [3:0] idx;
	logic       addr_ok;
	logic [7:0] rd_data;
	logic [31:0] prdata_reg;

	assign setup_ph = psel && !penable;
	// Unmapped or misaligned writes must not alias onto a real register
	assign wr_acc   = psel && penable && pwrite && addr_ok;
	assign win      = paddr[7:6];
	assign idx      = paddr[5:2];

	always_comb begin
		addr_ok = 1'b0;
		if (paddr[1:0] == 2'b00) begin
			if (win != 2'b11)
				addr_ok = (idx <= IDX_LAST);
			else
				addr_ok = (paddr >= FCFG_BASE && paddr <= FCFG_BASE + 8'h08) ||
					(paddr == TSR_ADDR) || (paddr == TPR_ADDR) || (paddr == IER_ADDR);
		end
	end

	// Zero wait states: read data is captured in setup so it is a flop in access
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata  = prdata_reg;

	// ****************************************************************
	// Transmit mailbox control and status
	// ****************************************************************
	logic [N_TX-1:0] transmit_request_reg;
	logic [N_TX-1:0] abort_request_reg;
	logic [N_TX-1:0] request_completed_reg;
	logic [N_TX-1:0] tx_success_flag_reg;
	logic [N_TX-1:0] arbitration_lost_flag_reg;
	logic [N_TX-1:0] tx_error_flag_reg;
	logic [N_TX-1:0] ctrl_wr;
	logic [N_TX-1:0] content_wr;
	logic [N_TX-1:0] new_req;
	logic [N_TX-1:0] clr_req;
	logic [N_TX-1:0] abort_set;
	logic [N_TX-1:0] attempt;
	logic [N_TX-1:0] abort_done;

	always_comb begin
		for (int i = 0; i < N_TX; i++) begin
			ctrl_wr[i]    = wr_acc && win == 2'(i) && idx == IDX_CTRL;
			// Content is frozen while the mailbox is pending
			content_wr[i] = wr_acc && win == 2'(i) && idx != IDX_CTRL && !transmit_request_reg[i];
			new_req[i]    = ctrl_wr[i] && pwdata[CS_TRANSMIT_REQUEST] && !transmit_request_reg[i];
			clr_req[i]    = ctrl_wr[i] && pwdata[CS_REQUEST_COMPLETED];
			abort_set[i]  = ctrl_wr[i] && pwdata[CS_ABORT_REQUEST] && transmit_request_reg[i];
			attempt[i]    = eng_done[i] && transmit_request_reg[i];
			// A frame already on the bus is allowed to finish first
			abort_done[i] = abort_request_reg[i] && transmit_request_reg[i] && !eng_busy[i] && !eng_done[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_request_reg <= '0;
			abort_request_reg <= '0;
			request_completed_reg <= '0;
			tx_success_flag_reg <= '0;
			arbitration_lost_flag_reg <= '0;
			tx_error_flag_reg <= '0;
		end else begin
			for (int i = 0; i < N_TX; i++) begin
				if (attempt[i]) begin
					// Hardware update wins over a software clear in the same cycle
					tx_error_flag_reg[i] <= (eng_result == CMF_RES_ERR);
					arbitration_lost_flag_reg[i] <= (eng_result == CMF_RES_ARB);
					tx_success_flag_reg[i] <= (eng_result == CMF_RES_OK);
					if (eng_result == CMF_RES_OK) begin
						transmit_request_reg[i] <= 1'b0;
						abort_request_reg[i] <= 1'b0;
						request_completed_reg[i] <= 1'b1;
					end else if (abort_set[i]) begin
						// Still pending after a failed try, so the abort must not be lost
						abort_request_reg[i] <= 1'b1;
					end
				end else if (abort_done[i]) begin
					transmit_request_reg[i] <= 1'b0;
					abort_request_reg[i] <= 1'b0;
					request_completed_reg[i] <= 1'b1;
					tx_success_flag_reg[i] <= 1'b0;
				end else begin
					if (new_req[i] || clr_req[i]) begin
						request_completed_reg[i] <= 1'b0;
						tx_success_flag_reg[i] <= 1'b0;
						arbitration_lost_flag_reg[i] <= 1'b0;
						tx_error_flag_reg[i] <= 1'b0;
					end
					if (new_req[i])
						transmit_request_reg[i] <= 1'b1;
					if (abort_set[i])
						abort_request_reg[i] <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Transmit mailbox content
	// ****************************************************************
	cmf_frame_s [N_TX-1:0] tx_frame_reg;

	// Content has no reset value; only the reserved bit is forced
	always_ff @(posedge pclk) begin
		for (int i = 0; i < N_TX; i++) begin
			if (content_wr[i]) begin
				if (idx == IDX_DLC)
					tx_frame_reg[i].dlc <= pwdata[3:0];
				else if (idx >= IDX_ID0 && idx < IDX_DATA0) begin
					tx_frame_reg[i].ident[2'(idx - IDX_ID0)] <= pwdata[7:0];
					if (idx == IDX_ID0)
						tx_frame_reg[i].ident[0][ID0_RSVD] <= 1'b0;
				end else if (idx >= IDX_DATA0)
					tx_frame_reg[i].data[3'(idx - IDX_DATA0)] <= pwdata[7:0];
			end
		end
	end

	assign tx_frame   = tx_frame_reg;
	assign tx_pending = transmit_request_reg;
	assign tx_abort   = abort_request_reg;

	// ****************************************************************
	// Receive mailbox
	// ****************************************************************
	cmf_frame_s rx_frame_reg;
	logic [7:0] fmi_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fmi_reg <= RST_FMI;
		else if (rx_store)
			fmi_reg <= rx_match_index;
	end

	// Software never writes here
	always_ff @(posedge pclk) begin
		if (rx_store) begin
			rx_frame_reg <= rx_frame;
			rx_frame_reg.ident[0][ID0_RSVD] <= 1'b0;
		end
	end

	// ****************************************************************
	// Filter configuration and interrupt enable
	// ****************************************************************
	logic [2:0][7:0] fcfg_reg;
	logic            mailbox_empty_irq_enable_reg;
	logic [1:0]      fc_sel;
	logic [7:0]      fc_keep;

	assign fc_sel = paddr[3:2];
	// Scale fields only move in initialization mode; active bits always
	assign fc_keep = init_mode ? FCFG_MASK : FCFG_ACT_MASK;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fcfg_reg <= {3{RST_FCFG}};
		else if (wr_acc && paddr[7:4] == FCFG_BASE[7:4] && fc_sel != 2'b11) begin
			fcfg_reg[fc_sel] <= (pwdata[7:0] & fc_keep) |
				(fcfg_reg[fc_sel] & ~fc_keep & FCFG_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mailbox_empty_irq_enable_reg <= 1'b0;
		else if (wr_acc && paddr == IER_ADDR)
			mailbox_empty_irq_enable_reg <= pwdata[0];
	end

	always_comb begin
		for (int f = 0; f < N_FILT; f++) begin
			filter_active[f] = fcfg_reg[f/2][(f%2)*FC_ODD_SHIFT];
			filter_scale[f]  = fcfg_reg[f/2][(f%2)*FC_ODD_SHIFT+FC_SCALE_LSB +: 2];
		end
	end

	// Value registers live with the engine; they must refuse writes while active
	assign filter_value_lock = filter_active;
	assign irq_tx_empty      = mailbox_empty_irq_enable_reg && |request_completed_reg;

	// ****************************************************************
	// Read mux
	// ****************************************************************
	logic [7:0] tsr_val;

	always_comb begin
		tsr_val = '0;
		for (int i = 0; i < N_TX; i++) begin
			tsr_val[i]           = request_completed_reg[i];
			tsr_val[TSR_TXOK0+i] = tx_success_flag_reg[i];
		end
	end

	always_comb begin
		cmf_frame_s fr;
		fr      = (win == 2'b10) ? rx_frame_reg : tx_frame_reg[win[0]];
		rd_data = '0;
		if (win != 2'b11) begin
			if (idx == IDX_CTRL) begin
				if (win == 2'b10)
					rd_data = fmi_reg;
				else
					rd_data = {2'b00, tx_error_flag_reg[win[0]], arbitration_lost_flag_reg[win[0]], tx_success_flag_reg[win[0]],
						request_completed_reg[win[0]], abort_request_reg[win[0]], transmit_request_reg[win[0]]};
			end else if (idx == IDX_DLC)
				rd_data = {4'h0, fr.dlc};
			else if (idx < IDX_DATA0)
				rd_data = fr.ident[2'(idx - IDX_ID0)];
			else if (idx <= IDX_LAST)
				rd_data = fr.data[3'(idx - IDX_DATA0)];
		end else if (paddr[7:4] == FCFG_BASE[7:4] && fc_sel != 2'b11)
			rd_data = fcfg_reg[fc_sel];
		else if (paddr == TSR_ADDR)
			rd_data = tsr_val;
		else if (paddr == TPR_ADDR)
			rd_data = {6'h00, ~transmit_request_reg};
		else if (paddr == IER_ADDR)
			rd_data = {7'h00, mailbox_empty_irq_enable_reg};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= '0;
		else if (setup_ph && !pwrite)
			prdata_reg <= {24'h000000, rd_data};
	end

	// ****************************************************************
	// Assertions (mailbox 0 and receive match index, abort wait and abort done on mailbox 1)
	// ****************************************************************
	property p_tx_error_flag;
		@(posedge pclk) disable iff (!presetn)
		attempt[0] && eng_result == CMF_RES_ERR |=> tx_error_flag_reg[0] && !tx_success_flag_reg[0] && transmit_request_reg[0];
	endproperty
	a_tx_error_flag: assert property (p_tx_error_flag) else $error("error bit not set");

	property p_arbitration_lost_flag;
		@(posedge pclk) disable iff (!presetn)
		attempt[0] && eng_result == CMF_RES_ARB |=> arbitration_lost_flag_reg[0] && !tx_error_flag_reg[0];
	endproperty
	a_arbitration_lost_flag: assert property (p_arbitration_lost_flag) else $error("arbitration bit not set");

	property p_tx_success_flag;
		@(posedge pclk) disable iff (!presetn)
		attempt[0] && eng_result == CMF_RES_OK |=> tx_success_flag_reg[0] && tsr_val[TSR_TXOK0]
			&& !arbitration_lost_flag_reg[0] && !tx_error_flag_reg[0];
	endproperty
	a_tx_success_flag: assert property (p_tx_success_flag) else $error("success bit wrong");

	property p_newreq;
		@(posedge pclk) disable iff (!presetn)
		new_req[0] && !attempt[0] && !abort_done[0] |=> transmit_request_reg[0] && !request_completed_reg[0] && !tsr_val[0];
	endproperty
	a_newreq: assert property (p_newreq) else $error("request did not clear completed");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		clr_req[0] && !attempt[0] && !abort_done[0] |=> !request_completed_reg[0] && !tx_success_flag_reg[0]
			&& !arbitration_lost_flag_reg[0] && !tx_error_flag_reg[0];
	endproperty
	a_clear: assert property (p_clear) else $error("clear left status bits");

	property p_abort_request_idle;
		@(posedge pclk) disable iff (!presetn)
		!transmit_request_reg[0] |-> ##1 !abort_request_reg[0];
	endproperty
	a_abort_request_idle: assert property (p_abort_request_idle) else $error("abort set while idle");

	property p_abort_wait;
		@(posedge pclk) disable iff (!presetn)
		abort_request_reg[1] && transmit_request_reg[1] && eng_busy[1] && !eng_done[1] |=> transmit_request_reg[1];
	endproperty
	a_abort_wait: assert property (p_abort_wait) else $error("abort cut a live frame");

	property p_abort_done;
		@(posedge pclk) disable iff (!presetn)
		abort_done[1] |=> !transmit_request_reg[1] && !abort_request_reg[1] && request_completed_reg[1] && !tx_success_flag_reg[1];
	endproperty
	a_abort_done: assert property (p_abort_done) else $error("abort did not empty mailbox");

	property p_fmi;
		@(posedge pclk) disable iff (!presetn)
		rx_store |=> fmi_reg == $past(rx_match_index);
	endproperty
	a_fmi: assert property (p_fmi) else $error("match index not stored");

	property p_lock;
		@(posedge pclk) disable iff (!presetn)
		wr_acc && win == 2'b00 && idx != IDX_CTRL && transmit_request_reg[0] |=> $stable(tx_frame_reg[0]);
	endproperty
	a_lock: assert property (p_lock) else $error("pending mailbox written");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		$rose(request_completed_reg[0]) && mailbox_empty_irq_enable_reg |-> irq_tx_empty;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt on completion");

	c_success: cover property (@(posedge pclk) disable iff (!presetn)
		new_req[0] ##[1:50] attempt[0] && eng_result == CMF_RES_OK);
	c_abort: cover property (@(posedge pclk) disable iff (!presetn)
		abort_set[1] ##[1:50] abort_done[1]);
	c_rx: cover property (@(posedge pclk) disable iff (!presetn)
		rx_store ##[1:20] (setup_ph && paddr == RX_BASE));

endmodule : cmf_regs

// file: cmf_regs_bench.sv
// Self-checking bench for the CAN mailbox and filter register block
`timescale 1ns/10ps

module cmf_regs_bench
	import cmf_pkg::*;
;
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                   init_mode, try_go, try_mb, rx_go, idle, rx_store, irq_tx_empty, err;
	logic [7:0]             paddr, rx_idx_in, rx_match_index, q;
	logic [31:0]            pwdata, prdata;
	logic [3:0]             try_len;
	cmf_result_e            try_res, eng_result;
	cmf_frame_s             rx_in, rx_frame, f;
	cmf_frame_s [N_TX-1:0]  tx_frame;
	logic [N_TX-1:0]        tx_pending, tx_abort, eng_busy, eng_done;
	logic [N_FILT-1:0][1:0] filter_scale;
	logic [N_FILT-1:0]      filter_active, filter_value_lock;
	int                     error_cnt, tests_run, cycles;

	cmf_regs u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_frame(tx_frame), .tx_pending(tx_pending),
		.tx_abort(tx_abort), .eng_busy(eng_busy), .eng_done(eng_done),
		.eng_result(eng_result), .rx_store(rx_store), .rx_frame(rx_frame),
		.rx_match_index(rx_match_index), .init_mode(init_mode),
		.filter_scale(filter_scale), .filter_active(filter_active),
		.filter_value_lock(filter_value_lock), .irq_tx_empty(irq_tx_empty));

	cmf_engine_model u_eng (.pclk(pclk), .presetn(presetn), .try_go(try_go),
		.try_mb(try_mb), .try_res(try_res), .try_len(try_len), .rx_go(rx_go),
		.rx_in(rx_in), .rx_idx_in(rx_idx_in), .tx_pending(tx_pending),
		.eng_busy(eng_busy), .eng_done(eng_done), .eng_result(eng_result),
		.rx_store(rx_store), .rx_frame(rx_frame), .rx_match_index(rx_match_index),
		.idle(idle));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Ends when pready is seen; only the bench timeout can end a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q   = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(nm, {8'h00, exp}, {8'h00, q});
	endtask : rchk

	task try_start(input logic mb, input cmf_result_e res, input logic [3:0] len);
		@(posedge pclk);
		try_go  <= 1'b1;
		try_mb  <= mb;
		try_res <= res;
		try_len <= len;
		@(posedge pclk);
		try_go <= 1'b0;
	endtask : try_start

	task try_wait;
		repeat (2) @(posedge pclk);
		while (idle !== 1'b1) begin
			@(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask : try_wait

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			summarize();
		end
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, init_mode, try_go, try_mb, rx_go} = '0;
		{paddr, pwdata, try_len, rx_idx_in} = '0;
		try_res = CMF_RES_OK;
		rx_in   = '0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctrl0", 8'h00, 8'h00);
		rchk("match", 8'h80, 8'h00);
		rchk("fcfg0", 8'hc0, 8'h00);
		rchk("tpr", 8'hd4, 8'h03);
		$display("test reset done");
		wr(8'h08, 8'hff);
		rchk("id0", 8'h08, 8'h7f);
		wr(8'h0c, 8'hc3);
		rchk("id1", 8'h0c, 8'hc3);
		wr(8'h10, 8'ha5);
		wr(8'h14, 8'h5a);
		rchk("id2", 8'h10, 8'ha5);
		rchk("id3", 8'h14, 8'h5a);
		wr(8'h04, 8'hff);
		rchk("dlc", 8'h04, 8'h0f);
		for (int i = 0; i < 8; i++) wr(8'(8'h18 + 4 * i), 8'(8'h10 + i));
		for (int i = 0; i < 8; i++) rchk("data", 8'(8'h18 + 4 * i), 8'(8'h10 + i));
		wr(8'h00, 8'hc2);
		rchk("ctrl_idle", 8'h00, 8'h00);
		$display("test content done");
		wr(8'h00, 8'h01);
		rchk("ctrl_req", 8'h00, 8'h01);
		rchk("tpr_busy", 8'hd4, 8'h02);
		wr(8'h04, 8'h03);
		wr(8'h18, 8'hee);
		rchk("dlc_lock", 8'h04, 8'h0f);
		rchk("data_lock", 8'h18, 8'h10);
		chk("frame_id2", 16'h00a5, {8'h00, tx_frame[0].ident[2]});
		try_start(1'b0, CMF_RES_ERR, 4'h2);
		try_wait();
		rchk("ctrl_err", 8'h00, 8'h21);
		try_start(1'b0, CMF_RES_ARB, 4'h2);
		try_wait();
		rchk("ctrl_arb", 8'h00, 8'h11);
		// Enable before the success so the interrupt follows the completion edge
		wr(8'hd8, 8'h01);
		rchk("ier", 8'hd8, 8'h01);
		chk("irq_fail", 16'h0000, {15'h0, irq_tx_empty});
		try_start(1'b0, CMF_RES_OK, 4'h3);
		try_wait();
		rchk("ctrl_ok", 8'h00, 8'h0c);
		rchk("tsr_ok", 8'hd0, 8'h11);
		rchk("tpr_ok", 8'hd4, 8'h03);
		chk("irq_on", 16'h0001, {15'h0, irq_tx_empty});
		wr(8'h00, 8'h04);
		rchk("ctrl_clr", 8'h00, 8'h00);
		rchk("tsr_clr", 8'hd0, 8'h00);
		chk("irq_off", 16'h0000, {15'h0, irq_tx_empty});
		$display("test transmit done");
		wr(8'h40, 8'h01);
		try_start(1'b1, CMF_RES_ARB, 4'hc);
		wr(8'h40, 8'h02);
		rchk("abort_wait", 8'h40, 8'h03);
		chk("abort_out", 16'h0002, {14'h0, tx_abort});
		try_wait();
		rchk("abort_done", 8'h40, 8'h14);
		rchk("tsr_abort", 8'hd0, 8'h02);
		wr(8'h40, 8'h01);
		rchk("rereq", 8'h40, 8'h01);
		wr(8'h40, 8'h02);
		rchk("abort_idle", 8'h40, 8'h04);
		chk("pend", 16'h0000, {14'h0, tx_pending});
		$display("test abort done");
		f = '0;
		f.ident[0] = 8'h45;
		f.data[0] = 8'h77;
		@(posedge pclk);
		rx_in     <= f;
		rx_idx_in <= 8'h2a;
		rx_go     <= 1'b1;
		@(posedge pclk);
		rx_go <= 1'b0;
		rchk("match", 8'h80, 8'h2a);
		rchk("rx_id0", 8'h88, 8'h45);
		wr(8'h98, 8'h00);
		rchk("rx_data", 8'h98, 8'h77);
		$display("test receive done");
		wr(8'hc0, 8'hff);
		rchk("fcfg0", 8'hc0, 8'h11);
		@(posedge pclk);
		init_mode <= 1'b1;
		wr(8'hc4, 8'hff);
		wr(8'hc8, 8'h25);
		rchk("fcfg1", 8'hc4, 8'h77);
		rchk("fcfg2", 8'hc8, 8'h25);
		chk("scale", 16'h06f0, {4'h0, filter_scale});
		chk("active", 16'h001f, {10'h0, filter_active});
		chk("lock", 16'h001f, {10'h0, filter_value_lock});
		$display("test filter done");
		apb(1'b0, 8'hfc, 8'h00);
		chk("slverr_top", 16'h0001, {15'h0, err});
		apb(1'b1, 8'h38, 8'hff);
		chk("slverr_gap", 16'h0001, {15'h0, err});
		$display("test unmapped done");
		summarize();
	end

endmodule : cmf_regs_bench
